/* File: verilog/spn_pkg.sv */
// Package of constants and types for the SAS PHY speed negotiation block.
package spn_pkg;

   // Link rates, lowest first.
   typedef enum logic [1:0] {
      SPN_RATE_G1,
      SPN_RATE_G2,
      SPN_RATE_G3,
      SPN_RATE_G4
   } spn_rate_e;

   // Capabilities word field positions and fixed values.
   localparam int SPN_START_BIT = 31;
   localparam int SPN_SSC_TYPE_BIT = 30;
   localparam int SPN_LLR_LSB = 24;
   localparam int SPN_SUPP_LSB = 16;
   localparam int SPN_PARITY_BIT = 0;
   localparam logic SPN_START_VAL = 1'h1;
   localparam logic SPN_SSC_TYPE_VAL = 1'h0;
   localparam logic [3:0] SPN_LLR_VAL = 4'h0;
   localparam logic [7:0] SPN_SUPP_ALL = 8'hFF;
   localparam logic [31:0] SPN_WORD_ZERO = 32'h0000_0000;

   // Settings mask: bit 0 = G4 with SSC (highest), bit 7 = G1 without SSC.
   localparam int SPN_NSET = 8;
   localparam logic [7:0] SPN_SET_NONE = 8'h00;

   // Cause codes for firmware notifications.
   typedef enum logic [2:0] {
      SPN_EV_NONE,
      SPN_EV_HOTPLUG_TO,
      SPN_EV_COMSAS_TO,
      SPN_EV_NO_MATCH,
      SPN_EV_RETRY_FAIL,
      SPN_EV_SYNC_LOSS,
      SPN_EV_LINK_UP
   } spn_cause_e;

   // Counter increment kinds.
   typedef enum logic [1:0] {
      SPN_CNT_NONE,
      SPN_CNT_RESET_PROB,
      SPN_CNT_SYNC_LOSS,
      SPN_CNT_INV_DWORD
   } spn_cnt_e;

   typedef struct packed {
      logic valid;
      spn_cause_e cause;
   } spn_note_s;

   typedef struct packed {
      logic valid;
      spn_cnt_e which;
   } spn_inc_s;

   // Out-of-band transmit requests.
   typedef struct packed {
      logic cominit;
      logic comsas;
      logic dc_zero;
   } spn_oob_tx_s;

   // Training selection handed to the analog side.
   typedef struct packed {
      logic start;
      spn_rate_e rate;
      logic ssc;
      logic tx_train;
   } spn_train_s;

   localparam int SPN_CNT_W = 32;
   localparam logic [31:0] SPN_CNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] SPN_CNT_ONE = 32'h0000_0001;
   localparam logic [31:0] SPN_CNT_MAX = 32'hFFFF_FFFF;

   // APB register offsets (bytes).
   localparam logic [7:0] SPN_A_CTRL = 8'h00;
   localparam logic [7:0] SPN_A_STATUS = 8'h04;
   localparam logic [7:0] SPN_A_CAPWORD = 8'h08;
   localparam logic [7:0] SPN_A_RESETPROB = 8'h0C;
   localparam logic [7:0] SPN_A_SYNCLOSS = 8'h10;
   localparam logic [7:0] SPN_A_INVDWORD = 8'h14;
   localparam logic [7:0] SPN_A_RDERR = 8'h18;
   localparam logic [7:0] SPN_A_LASTEV = 8'h1C;

   // CTRL fields.
   localparam int SPN_CTRL_MAXRATE_LSB = 0;
   localparam int SPN_CTRL_CLRCNT_BIT = 4;
   localparam logic [1:0] SPN_MAXRATE_RST = 2'h3;

   // Timeouts in microseconds and cycles at 100 MHz.
   localparam int SPN_CLK_MHZ = 100;
   localparam int SPN_HOTPLUG_US = 10000;
   localparam int SPN_COMSAS_US = 14;
   localparam int SPN_SYNC_US = 1;
   localparam int SPN_HOTPLUG_CYC = SPN_HOTPLUG_US * SPN_CLK_MHZ;
   localparam int SPN_COMSAS_CYC = SPN_COMSAS_US * SPN_CLK_MHZ;
   localparam int SPN_SYNC_CYC = SPN_SYNC_US * SPN_CLK_MHZ;
   localparam int SPN_TMR_W = 24;
   localparam logic [23:0] SPN_TMR_ONE = 24'h00_0001;
   localparam logic [23:0] SPN_TMR_ZERO = 24'h00_0000;

endpackage : spn_pkg

/* File: verilog/spn_phy_neg.sv */
// SAS PHY speed negotiation, training selection and PHY error handling.
//
// Operation
// - Negotiate G1 to G4; default limit G4.
// - Progress SNW-1, SNW-2, SNW-3 with capability exchange.
// - Transmitter training only at 12G rate.
// - Start bit one; bytes 2,3 zero except parity.
// - Spread-type bit sent as zero.
// - Requested logical link rate sent zero.
// - All eight support bits sent set.
// - Parity makes set capability bits even.
// - Train highest untried common setting first.
// - Failed training retries next untried common setting.
// - Priority G4 SSC down to G1 no SSC.
// - Power-on or hard reset sends one COMINIT.
// - Hot-plug timeout: DC zero, wait, notify.
// - COMSAS timeout: notify, DC zero, await COMINIT.
// - No match or retry fail: notify, wait.
// - Retry failure bumps PHY reset problem counter.
// - Sync loss: notify, COMINIT, bump counter.
// - Invalid dword counted; disparity counter unused.
// - OOB bursts of ALIGN separated by idle; the OOB engine sends them, this block only requests.
`timescale 1ns/1ps
module spn_phy_neg
   import spn_pkg::*;
#(
   parameter int HOTPLUG_CYC = SPN_HOTPLUG_CYC,
   parameter int COMSAS_CYC = SPN_COMSAS_CYC,
   parameter int SYNC_CYC = SPN_SYNC_CYC
) (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic HARD_RESET_I,
   input wire logic COMINIT_DET_I,
   input wire logic COMSAS_DET_I,
   input wire logic OOB_TX_DONE_I,
   input wire logic SNW_DONE_I,
   input wire logic SNW_OK_I,
   input wire logic CAP_RX_VALID_I,
   input wire logic [31:0] CAP_RX_I,
   input wire logic TRAIN_DONE_I,
   input wire logic TRAIN_OK_I,
   input wire logic RETRY_DONE_I,
   input wire logic RETRY_OK_I,
   input wire logic SYNC_LOST_I,
   input wire logic INV_DWORD_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output spn_oob_tx_s OOB_TX_O,
   output logic [1:0] SNW_STEP_O,
   output logic CAP_TX_VALID_O,
   output logic [31:0] CAP_TX_O,
   output spn_train_s TRAIN_O,
   output logic LINK_UP_O,
   output spn_note_s NOTE_O,
   output spn_inc_s INC_O
);

   typedef enum logic [3:0] {
      ST_SEND_INIT, ST_WAIT_INIT, ST_SEND_SAS, ST_WAIT_SAS,
      ST_SNW, ST_SNW3, ST_PICK, ST_TRAIN, ST_RETRY, ST_IDLE_DC, ST_UP
   } spn_state_e;

   spn_state_e state_r;
   logic [23:0] tmr_r;
   logic [7:0] tried_r;
   logic [7:0] common_r;
   logic [2:0] sel_r;
   logic [1:0] maxrate_r;
   logic [31:0] cnt_rp_r;
   logic [31:0] cnt_sl_r;
   logic [31:0] cnt_id_r;
   spn_cause_e last_r;
   logic clr_cnt;

   // Fixed capability word built from named fields.
   // Parity covers every set bit, start bit included.
   logic [31:0] cap_word;
   always_comb begin
      cap_word = SPN_WORD_ZERO;
      cap_word[SPN_START_BIT] = SPN_START_VAL;
      cap_word[SPN_SSC_TYPE_BIT] = SPN_SSC_TYPE_VAL;
      cap_word[SPN_LLR_LSB +: 4] = SPN_LLR_VAL;
      cap_word[SPN_SUPP_LSB +: 8] = SPN_SUPP_ALL;
      cap_word[SPN_PARITY_BIT] = ^cap_word;
   end

   // Support bits keep their order, so index 0 is the top priority setting.
   // Settings above the software rate limit are masked out.
   logic [7:0] allowed;
   logic [7:0] cand;
   always_comb begin
      for (int i = 0; i < SPN_NSET; i++) begin
         allowed[i] = (2'(3 - i / 2) <= maxrate_r);
      end
   end
   assign cand = common_r & allowed & ~tried_r;

   // Priority encoder: lowest index wins.
   logic cand_any;
   logic [2:0] cand_idx;
   always_comb begin
      cand_any = 1'b0;
      cand_idx = 3'h0;
      for (int i = SPN_NSET - 1; i >= 0; i--) begin
         if (cand[i]) begin
            cand_any = 1'b1;
            cand_idx = 3'(i);
         end
      end
   end

   // Received byte 1 keeps its order: bit 0, G4 with
   // spreading, lands on index 0, the top priority.
   logic [7:0] rx_supp;
   always_comb begin
      for (int i = 0; i < SPN_NSET; i++) begin
         rx_supp[i] = CAP_RX_I[SPN_SUPP_LSB + i];
      end
   end

   // Expiry is seen at one, so a zero timer is idle.
   logic timeout;
   assign timeout = (tmr_r == SPN_TMR_ONE);

   // Main link reset sequencer.
   always_ff @(posedge CLOCK_I) begin
      // Hard reset restarts like power-on; counters stay.
      if (!NRST_I || HARD_RESET_I) begin
         state_r <= ST_SEND_INIT;
         tmr_r <= SPN_TMR_ZERO;
         tried_r <= SPN_SET_NONE;
         common_r <= SPN_SET_NONE;
         sel_r <= 3'h0;
         OOB_TX_O <= '0;
         SNW_STEP_O <= 2'h0;
         CAP_TX_VALID_O <= 1'b0;
         CAP_TX_O <= SPN_WORD_ZERO;
         TRAIN_O <= '0;
         LINK_UP_O <= 1'b0;
         NOTE_O <= '0;
         INC_O <= '0;
      end else begin
         NOTE_O <= '0;
         INC_O <= '0;
         OOB_TX_O.cominit <= 1'b0;
         OOB_TX_O.comsas <= 1'b0;
         CAP_TX_VALID_O <= 1'b0;
         TRAIN_O.start <= 1'b0;
         if (tmr_r != SPN_TMR_ZERO) tmr_r <= tmr_r - SPN_TMR_ONE;
         unique case (state_r)
            ST_SEND_INIT: begin
               // One COMINIT request; the OOB engine sends the bursts.
               OOB_TX_O <= '{cominit: 1'b1, comsas: 1'b0, dc_zero: 1'b0};
               state_r <= ST_WAIT_INIT;
               tmr_r <= SPN_TMR_W'(HOTPLUG_CYC);
               LINK_UP_O <= 1'b0;
            end
            ST_WAIT_INIT: begin
               OOB_TX_O.dc_zero <= 1'b1;
               if (COMINIT_DET_I || COMSAS_DET_I) begin
                  state_r <= ST_SEND_SAS;
               end else if (timeout) begin
                  // Not an error: keep waiting, rearm the timer.
                  NOTE_O <= '{valid: 1'b1, cause: SPN_EV_HOTPLUG_TO};
                  tmr_r <= SPN_TMR_W'(HOTPLUG_CYC);
               end
            end
            ST_SEND_SAS: begin
               OOB_TX_O <= '{cominit: 1'b0, comsas: 1'b1, dc_zero: 1'b0};
               tmr_r <= SPN_TMR_W'(COMSAS_CYC);
               state_r <= ST_WAIT_SAS;
            end
            ST_WAIT_SAS: begin
               // A COMINIT here is ignored until COMSAS or expiry.
               if (COMSAS_DET_I) begin
                  state_r <= ST_SNW;
                  SNW_STEP_O <= 2'h1;
               end else if (timeout) begin
                  NOTE_O <= '{valid: 1'b1, cause: SPN_EV_COMSAS_TO};
                  state_r <= ST_IDLE_DC;
               end
            end
            ST_SNW: begin
               if (SNW_DONE_I && !SNW_OK_I) begin
                  // A window with no usable rate ends the attempt.
                  NOTE_O <= '{valid: 1'b1, cause: SPN_EV_NO_MATCH};
                  state_r <= ST_IDLE_DC;
               end else if (SNW_DONE_I) begin
                  if (SNW_STEP_O == 2'h2) begin
                     state_r <= ST_SNW3;
                     SNW_STEP_O <= 2'h3;
                     CAP_TX_O <= cap_word;
                     CAP_TX_VALID_O <= 1'b1;
                  end else begin
                     SNW_STEP_O <= SNW_STEP_O + 2'h1;
                  end
               end
            end
            ST_SNW3: begin
               if (CAP_RX_VALID_I) begin
                  // All our support bits are set, so the common
                  // set is what the partner offered.
                  common_r <= rx_supp & SPN_SUPP_ALL;
                  tried_r <= SPN_SET_NONE;
                  state_r <= ST_PICK;
               end
            end
            ST_PICK: begin
               // Each pick is marked tried, so none repeats.
               if (cand_any) begin
                  sel_r <= cand_idx;
                  tried_r[cand_idx] <= 1'b1;
                  TRAIN_O.start <= 1'b1;
                  TRAIN_O.rate <= spn_rate_e'(2'(3 - cand_idx / 3'h2));
                  TRAIN_O.ssc <= ~cand_idx[0];
                  TRAIN_O.tx_train <= (cand_idx / 3'h2 == 3'h0);
                  state_r <= ST_TRAIN;
               end else begin
                  NOTE_O <= '{valid: 1'b1, cause: SPN_EV_NO_MATCH};
                  state_r <= ST_IDLE_DC;
               end
            end
            ST_TRAIN: begin
               // A failed attempt picks the next untried one.
               if (TRAIN_DONE_I) begin
                  state_r <= TRAIN_OK_I ? ST_RETRY : ST_PICK;
               end
            end
            ST_RETRY: begin
               // Final check at the matched rate.
               if (RETRY_DONE_I) begin
                  if (RETRY_OK_I) begin
                     state_r <= ST_UP;
                     LINK_UP_O <= 1'b1;
                     SNW_STEP_O <= 2'h0;
                     NOTE_O <= '{valid: 1'b1, cause: SPN_EV_LINK_UP};
                     tmr_r <= SPN_TMR_ZERO;
                  end else begin
                     NOTE_O <= '{valid: 1'b1, cause: SPN_EV_RETRY_FAIL};
                     INC_O <= '{valid: 1'b1, which: SPN_CNT_RESET_PROB};
                     state_r <= ST_IDLE_DC;
                  end
               end
            end
            ST_IDLE_DC: begin
               OOB_TX_O.dc_zero <= 1'b1;
               SNW_STEP_O <= 2'h0;
               if (COMINIT_DET_I) state_r <= ST_SEND_SAS;
            end
            ST_UP: begin
               OOB_TX_O.dc_zero <= 1'b0;
               if (!SYNC_LOST_I) begin
                  tmr_r <= SPN_TMR_W'(SYNC_CYC);
               end else if (tmr_r == SPN_TMR_ZERO) begin
                  tmr_r <= SPN_TMR_W'(SYNC_CYC);
               end else if (timeout) begin
                  NOTE_O <= '{valid: 1'b1, cause: SPN_EV_SYNC_LOSS};
                  INC_O <= '{valid: 1'b1, which: SPN_CNT_SYNC_LOSS};
                  state_r <= ST_SEND_INIT;
               end
               // Sync loss owns the one increment slot; a dword
               // bad in that same cycle goes uncounted.
               if (INV_DWORD_I && !(SYNC_LOST_I && timeout)) begin
                  INC_O <= '{valid: 1'b1, which: SPN_CNT_INV_DWORD};
               end
            end
            default: state_r <= ST_SEND_INIT;
         endcase
      end
   end

   // Saturating counters; a bump wins over a software clear.
   function automatic logic [31:0] bump(input logic [31:0] v);
      return (v == SPN_CNT_MAX) ? v : v + SPN_CNT_ONE;
   endfunction

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         cnt_rp_r <= SPN_CNT_ZERO;
         cnt_sl_r <= SPN_CNT_ZERO;
         cnt_id_r <= SPN_CNT_ZERO;
      end else begin
         if (INC_O.valid && INC_O.which == SPN_CNT_RESET_PROB) begin
            cnt_rp_r <= bump(cnt_rp_r);
         end else if (clr_cnt) begin
            cnt_rp_r <= SPN_CNT_ZERO;
         end
         if (INC_O.valid && INC_O.which == SPN_CNT_SYNC_LOSS) begin
            cnt_sl_r <= bump(cnt_sl_r);
         end else if (clr_cnt) begin
            cnt_sl_r <= SPN_CNT_ZERO;
         end
         if (INC_O.valid && INC_O.which == SPN_CNT_INV_DWORD) begin
            cnt_id_r <= bump(cnt_id_r);
         end else if (clr_cnt) begin
            cnt_id_r <= SPN_CNT_ZERO;
         end
      end
   end

   // The last cause outlives the one-cycle notice.
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         last_r <= SPN_EV_NONE;
      end else if (NOTE_O.valid) begin
         last_r <= NOTE_O.cause;
      end
   end

   // APB slave: zero wait states, unmapped addresses answer with an error.
   logic setup;
   logic wr;
   logic mapped;
   assign setup = PSEL_I && !PENABLE_I;
   // A write lands only at the edge that sees PREADY.
   assign wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
   assign clr_cnt = wr && PADDR_I == SPN_A_CTRL &&
                    PWDATA_I[SPN_CTRL_CLRCNT_BIT];
   always_comb begin
      unique case (PADDR_I)
         SPN_A_CTRL, SPN_A_STATUS, SPN_A_CAPWORD, SPN_A_RESETPROB,
         SPN_A_SYNCLOSS, SPN_A_INVDWORD, SPN_A_RDERR, SPN_A_LASTEV:
            mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // A new limit applies at the next pick; a training
   // under way keeps its rate.
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         maxrate_r <= SPN_MAXRATE_RST;
      end else if (wr && PADDR_I == SPN_A_CTRL) begin
         maxrate_r <= PWDATA_I[SPN_CTRL_MAXRATE_LSB +: 2];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= SPN_WORD_ZERO;
      end else begin
         PREADY_O <= setup;
         PSLVERR_O <= setup && !mapped;
         PRDATA_O <= SPN_WORD_ZERO;
         // Read data is latched at setup for the access.
         if (setup && !PWRITE_I) begin
            unique case (PADDR_I)
               SPN_A_CTRL: PRDATA_O <= {30'h0, maxrate_r};
               SPN_A_STATUS: PRDATA_O <= {20'h0, state_r, 1'b0, sel_r,
                                          LINK_UP_O, 1'b0, SNW_STEP_O};
               SPN_A_CAPWORD: PRDATA_O <= cap_word;
               SPN_A_RESETPROB: PRDATA_O <= cnt_rp_r;
               SPN_A_SYNCLOSS: PRDATA_O <= cnt_sl_r;
               SPN_A_INVDWORD: PRDATA_O <= cnt_id_r;
               SPN_A_RDERR: PRDATA_O <= SPN_CNT_ZERO;
               SPN_A_LASTEV: PRDATA_O <= {29'h0, last_r};
               default: PRDATA_O <= SPN_WORD_ZERO;
            endcase
         end
      end
   end

endmodule // spn_phy_neg

/* File: testbench/spn_phy_neg_chk.sv */
// Port-level assertion checker for the speed negotiation block.
`timescale 1ns/1ps
module spn_phy_neg_chk
   import spn_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic COMINIT_DET_I,
   input wire logic RETRY_DONE_I,
   input wire logic RETRY_OK_I,
   input wire logic INV_DWORD_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PREADY_O,
   input wire spn_oob_tx_s OOB_TX_O,
   input wire logic CAP_TX_VALID_O,
   input wire logic [31:0] CAP_TX_O,
   input wire spn_train_s TRAIN_O,
   input wire logic LINK_UP_O,
   input wire spn_note_s NOTE_O,
   input wire spn_inc_s INC_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!NRST_I);

   sequence s_cap;
      CAP_TX_VALID_O;
   endsequence
   sequence s_sync_note;
      NOTE_O.valid && NOTE_O.cause == SPN_EV_SYNC_LOSS;
   endsequence
   sequence s_relink;
      ##[0:4] OOB_TX_O.cominit;
   endsequence

   a_start_bit: assert property (s_cap |-> CAP_TX_O[31] &&
      CAP_TX_O[15:1] == 15'h0000) else $error("start or zero bytes bad");
   a_ssc_type: assert property (s_cap |-> !CAP_TX_O[30])
      else $error("spread type bit set");
   a_llr_zero: assert property (s_cap |-> CAP_TX_O[27:24] == 4'h0)
      else $error("logical rate field not zero");
   a_supp_all: assert property (s_cap |-> CAP_TX_O[23:16] == 8'hFF)
      else $error("support bits not all set");
   a_even_par: assert property (s_cap |-> ^CAP_TX_O == 1'b0)
      else $error("capability parity odd");
   a_tx_train: assert property (TRAIN_O.start |->
      TRAIN_O.tx_train == (TRAIN_O.rate == SPN_RATE_G4))
      else $error("tx training at wrong rate");
   a_one_cominit: assert property ($rose(NRST_I) |->
      ##[0:2] (OOB_TX_O.cominit ##1 !OOB_TX_O.cominit))
      else $error("no single cominit after reset");
   a_comsas_ans: assert property (COMINIT_DET_I && !LINK_UP_O |->
      ##[1:3] OOB_TX_O.comsas) else $error("no comsas answer");
   a_wait_idle: assert property (NOTE_O.valid &&
      NOTE_O.cause inside {SPN_EV_HOTPLUG_TO, SPN_EV_COMSAS_TO,
      SPN_EV_NO_MATCH, SPN_EV_RETRY_FAIL} |->
      ##[0:2] (OOB_TX_O.dc_zero && !LINK_UP_O))
      else $error("not idling after failure");
   a_retry_cnt: assert property (RETRY_DONE_I && !RETRY_OK_I |->
      ##[1:3] (INC_O.valid && INC_O.which == SPN_CNT_RESET_PROB))
      else $error("reset problem not counted");
   a_sync_seq: assert property (s_sync_note |-> s_relink)
      else $error("no cominit after sync loss");
   a_inv_cnt: assert property (INV_DWORD_I && LINK_UP_O |->
      ##[1:2] (INC_O.valid && INC_O.which == SPN_CNT_INV_DWORD))
      else $error("invalid dword not counted");
   a_note_pulse: assert property (NOTE_O.valid |=> !NOTE_O.valid)
      else $error("notification longer than a cycle");
   a_inc_pulse: assert property (INC_O.valid |=> !INC_O.valid)
      else $error("increment longer than a cycle");
   a_apb_ready: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
      else $error("no ready in access cycle");
endmodule // spn_phy_neg_chk

bind spn_phy_neg spn_phy_neg_chk i_spn_phy_neg_chk (.*);

/* File: testbench/spn_link_partner.sv */
// Behavioural model of the attached partner PHY on the link.
`timescale 1ns/1ps
module spn_link_partner
   import spn_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [1:0] mode_i,
   input wire logic [31:0] cap_i,
   input wire logic [3:0] fails_i,
   input wire logic [3:0] dly_i,
   input wire logic retry_ok_i,
   input wire spn_oob_tx_s oob_i,
   input wire logic [1:0] step_i,
   input wire logic cap_v_i,
   input wire spn_train_s train_i,
   output logic cominit_o,
   output logic comsas_o,
   output logic snw_done_o,
   output logic cap_v_o,
   output logic [31:0] cap_o,
   output logic train_done_o,
   output logic train_ok_o,
   output logic retry_done_o,
   output logic retry_ok_o
);
   logic [3:0] tmr_r;
   logic [2:0] ev_r;
   logic [3:0] left_r;
   logic [1:0] step_r;
   logic cap_d_r;
   logic ok_r;

   // Stale lines are inverted so a late sample never looks valid.
   assign cap_o = cap_v_o ? cap_i : ~cap_i;
   assign train_ok_o = train_done_o ? ok_r : ~ok_r;
   assign retry_ok_o = retry_done_o ? retry_ok_i : ~retry_ok_i;

   // Mode 0 answers no OOB, mode 1 answers only COMINIT OOB, mode 2 runs fully.
   always_ff @(posedge clk_i) begin
      {cominit_o, comsas_o, snw_done_o, train_done_o, retry_done_o} <= '0;
      cap_d_r <= cap_v_i;
      cap_v_o <= cap_d_r;
      if (!nrst_i) begin
         ev_r <= 3'h0;
         tmr_r <= 4'h0;
         step_r <= 2'h0;
         ok_r <= 1'b0;
      end else if (ev_r != 3'h0) begin
         tmr_r <= tmr_r - 4'h1;
         if (tmr_r == 4'h0) begin
            ev_r <= 3'h0;
            case (ev_r)
               3'h1: cominit_o <= 1'b1;
               3'h2: comsas_o <= 1'b1;
               3'h3: snw_done_o <= 1'b1;
               3'h4: begin
                  train_done_o <= 1'b1;
                  ok_r <= (left_r == 4'h0);
                  if (left_r != 4'h0) begin
                     left_r <= left_r - 4'h1;
                  end else begin
                     ev_r <= 3'h5;
                     tmr_r <= dly_i;
                  end
               end
               default: retry_done_o <= 1'b1;
            endcase
         end
      end else begin
         tmr_r <= dly_i;
         step_r <= step_i;
         if (oob_i.cominit && mode_i != 2'h0) begin
            ev_r <= 3'h1;
         end else if (oob_i.comsas && mode_i == 2'h2) begin
            ev_r <= 3'h2;
         // SNW-3 ends with the capability exchange instead.
         end else if (step_i != step_r && step_i inside {2'h1, 2'h2}) begin
            ev_r <= 3'h3;
         end else if (train_i.start) begin
            ev_r <= 3'h4;
         end
      end
      if (cap_v_i) begin
         left_r <= fails_i;
      end
   end
endmodule // spn_link_partner

/* File: testbench/tb_spn_phy_neg.sv */
// Self-checking bench for the speed negotiation block.
`timescale 1ns/1ps
module tb_spn_phy_neg;
   import spn_pkg::*;
   logic CLOCK_I, NRST_I, HARD_RESET_I, COMINIT_DET_I, COMSAS_DET_I;
   logic OOB_TX_DONE_I, SNW_DONE_I, SNW_OK_I, CAP_RX_VALID_I;
   logic TRAIN_DONE_I, TRAIN_OK_I, RETRY_DONE_I, RETRY_OK_I;
   logic SYNC_LOST_I, INV_DWORD_I, PSEL_I, PENABLE_I, PWRITE_I;
   logic PREADY_O, PSLVERR_O, CAP_TX_VALID_O, LINK_UP_O, e;
   logic [7:0] PADDR_I;
   logic [31:0] CAP_RX_I, PWDATA_I, PRDATA_O, CAP_TX_O, q, pcap;
   logic [1:0] SNW_STEP_O, mode;
   spn_oob_tx_s OOB_TX_O;
   spn_train_s TRAIN_O;
   spn_note_s NOTE_O;
   spn_inc_s INC_O;
   logic [3:0] fails, dly;
   logic rok;
   int err_count, comparisons, cyc, n_ci;
   logic [2:0] tq[$];

   assign OOB_TX_DONE_I = 1'b0;
   assign SNW_OK_I = 1'b1;

   // Short timeouts keep the run brief.
   spn_phy_neg #(.HOTPLUG_CYC(20), .COMSAS_CYC(10), .SYNC_CYC(5))
      i_spn_phy_neg (.*);
   spn_link_partner i_spn_link_partner (.clk_i(CLOCK_I), .nrst_i(NRST_I),
      .mode_i(mode), .cap_i(pcap), .fails_i(fails), .dly_i(dly),
      .retry_ok_i(rok), .oob_i(OOB_TX_O), .step_i(SNW_STEP_O),
      .cap_v_i(CAP_TX_VALID_O), .train_i(TRAIN_O),
      .cominit_o(COMINIT_DET_I), .comsas_o(COMSAS_DET_I),
      .snw_done_o(SNW_DONE_I), .cap_v_o(CAP_RX_VALID_I), .cap_o(CAP_RX_I),
      .train_done_o(TRAIN_DONE_I), .train_ok_o(TRAIN_OK_I),
      .retry_done_o(RETRY_DONE_I), .retry_ok_o(RETRY_OK_I));

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, x);
      comparisons++;
      if (s !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge CLOCK_I);
      PSEL_I <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLOCK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLOCK_I); while (PREADY_O !== 1'b1);
      q = PRDATA_O;
      e = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, x,
      input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, q & m, x);
   endtask

   task automatic wait_for(input spn_cause_e c);
      do @(posedge CLOCK_I);
      while (!(NOTE_O.valid === 1'b1 && NOTE_O.cause === c));
   endtask

   task automatic hard_reset();
      @(posedge CLOCK_I);
      HARD_RESET_I <= 1'b1;
      @(posedge CLOCK_I);
      HARD_RESET_I <= 1'b0;
   endtask

   // Setting index 0 is G4 with spreading, index 7 is G1 without.
   function automatic logic [2:0] sexp(input int i);
      return {2'(3 - i / 2), i % 2 == 0};
   endfunction

   task automatic chk_order(input int n, input int s[3]);
      chk("train count", tq.size(), n);
      for (int k = 0; k < n && k < tq.size(); k++)
         chk("train setting", tq[k], sexp(s[k]));
      tq.delete();
   endtask

   initial begin
      CLOCK_I = 1'b0;
      forever #5 CLOCK_I = ~CLOCK_I;
   end

   always @(posedge CLOCK_I) begin
      cyc++;
      if (TRAIN_O.start === 1'b1)
         tq.push_back({TRAIN_O.rate, TRAIN_O.ssc});
      if (OOB_TX_O.cominit === 1'b1)
         n_ci++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end

   initial begin
      {NRST_I, HARD_RESET_I, SYNC_LOST_I, INV_DWORD_I} = 4'h0;
      {PSEL_I, PENABLE_I, PWRITE_I, rok} = 4'h1;
      PADDR_I = 8'h00;
      PWDATA_I = 32'h0000_0000;
      mode = 2'h0;
      pcap = 32'hC0FF_0000;
      fails = 4'h2;
      dly = 4'h4;
      repeat (16) @(posedge CLOCK_I);
      NRST_I <= 1'b1;
      rd(SPN_A_CTRL, 32'h3, 32'h3, "max rate");
      rd(SPN_A_CAPWORD, '1, 32'h80FF_0001, "cap");
      chk("spread type", q[30], 1'b0);
      chk("logical rate", q[27:24], 4'h0);
      chk("support", q[23:16], 8'hFF);
      rd(SPN_A_RDERR, '1, 32'h0, "disparity");
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", e, 1'b1);
      wait_for(SPN_EV_HOTPLUG_TO);
      chk("dc zero", OOB_TX_O.dc_zero, 1'b1);
      chk("cominits", n_ci, 1);
      mode <= 2'h1;
      hard_reset();
      wait_for(SPN_EV_COMSAS_TO);
      chk("cominits", n_ci, 2);
      mode <= 2'h2;
      hard_reset();
      wait_for(SPN_EV_LINK_UP);
      chk_order(3, '{0, 1, 2});
      rd(SPN_A_STATUS, 32'h78, 32'h28, "status");
      repeat (3) begin
         @(posedge CLOCK_I);
         INV_DWORD_I <= 1'b1;
         @(posedge CLOCK_I);
         INV_DWORD_I <= 1'b0;
      end
      rd(SPN_A_INVDWORD, '1, 32'h3, "inv dwords");
      fails <= 4'h0;
      rok <= 1'b0;
      @(posedge CLOCK_I);
      SYNC_LOST_I <= 1'b1;
      wait_for(SPN_EV_SYNC_LOSS);
      SYNC_LOST_I <= 1'b0;
      wait_for(SPN_EV_RETRY_FAIL);
      rd(SPN_A_SYNCLOSS, '1, 32'h1, "sync loss");
      rd(SPN_A_RESETPROB, '1, 32'h1, "reset prob");
      apb(1'b1, SPN_A_CTRL, 32'h0000_0011);
      rd(SPN_A_RESETPROB, '1, 32'h0, "cleared");
      // Partner offers G3 SSC, G2 plain and G1 SSC; limit G2 hides G3.
      pcap <= 32'h8064_0000;
      fails <= 4'hF;
      tq.delete();
      hard_reset();
      wait_for(SPN_EV_NO_MATCH);
      chk_order(2, '{5, 6, 0});
      chk("link up", LINK_UP_O, 1'b0);
      rd(SPN_A_RESETPROB, '1, 32'h0, "no count");
      complete_run();
   end
endmodule // tb_spn_phy_neg
